// ==== core/sbg_pkg.sv ====
// Constants, register map and types for the serial baud generator
// Contract
// - Source codes 0 to 7 pick main clock divided by 2^n, n = code + 1.
// - Source code 8 makes the external baud clock pin the prescaler source; here the pin bypasses the prescaler and is used in UART mode only.
// - UART bit rate from main clock is main clock / (2^(n+1) * 8).
// - UART bit rate from the external pin is its frequency / 16.
// - 3-wire internal serial clock is main clock / 2^(n+1).
// - External 3-wire serial clock ignores the baud source setting.
// - Three modes only: operation stop, UART, 3-wire synchronous.
// - Operation stop does no transfer; shared pins return to port use.
// - Operation stop decided jointly by serial and async mode registers.
// - Serial mode bit 7 enables 3-wire operation.
// - Reset clears baud source and serial mode registers to 00H.
package sbg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [15:0] SBG_IDX_ASYNC  = 16'hff70;
    localparam logic [15:0] SBG_IDX_MODE   = 16'hff72;
    localparam logic [15:0] SBG_IDX_BAUD   = 16'hff73;
    localparam logic [15:0] SBG_IDX_STATUS = 16'hff74;

    localparam logic [31:0] SBG_ADDR_ASYNC  = {14'h0000, SBG_IDX_ASYNC, 2'b00};
    localparam logic [31:0] SBG_ADDR_MODE   = {14'h0000, SBG_IDX_MODE, 2'b00};
    localparam logic [31:0] SBG_ADDR_BAUD   = {14'h0000, SBG_IDX_BAUD, 2'b00};
    localparam logic [31:0] SBG_ADDR_STATUS = {14'h0000, SBG_IDX_STATUS, 2'b00};

    // Values after reset
    localparam logic [7:0] SBG_RST_ASYNC = 8'h00;
    localparam logic [7:0] SBG_RST_MODE  = 8'h00;
    localparam logic [7:0] SBG_RST_BAUD  = 8'h00;

    // Writable bit masks; other bits read as zero
    localparam logic [7:0] SBG_MASK_ASYNC = 8'hfc;
    localparam logic [7:0] SBG_MASK_MODE  = 8'hcf;
    localparam logic [7:0] SBG_MASK_BAUD  = 8'hf0;

    // Field positions
    localparam int SBG_BIT_TX_EN     = 7;
    localparam int SBG_BIT_RX_EN     = 6;
    localparam int SBG_BIT_3W_EN     = 7;
    localparam int SBG_BIT_CLK_INT   = 1;
    localparam int SBG_BIT_CLK_PHASE = 0;
    localparam int SBG_SRC_LSB       = 4;

    // Source codes
    localparam logic [3:0] SBG_CODE_MAX_INT = 4'h7;
    localparam logic [3:0] SBG_CODE_EXT     = 4'h8;

    // Prescaler and bit rate counts
    localparam int         SBG_PRE_W      = 8;
    localparam logic [3:0] SBG_UART_LAST  = 4'hf;

    // Operating modes, one-hot
    typedef enum logic [2:0] {
        SBG_ST_STOP = 3'b001,
        SBG_ST_UART = 3'b010,
        SBG_ST_3W   = 3'b100
    } sbg_mode_t;

endpackage

// ==== core/sbg_pin_sync.sv ====
// Three-flop pin synchroniser with debounced level and edge pulses
`timescale 1ns/1ps
module sbg_pin_sync (
    input  wire logic core_clk_i,
    input  wire logic rst_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic meta_reg;
    logic s2_reg;
    logic s3_reg;

    // Chain; only s2 reads meta
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            s2_reg   <= 1'b0;
            s3_reg   <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            s2_reg   <= meta_reg;
            s3_reg   <= s2_reg;
        end
    end

    // Level moves only when stages two and three agree
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            rise_o <= (s2_reg == s3_reg) && s3_reg && !level_o;
            fall_o <= (s2_reg == s3_reg) && !s3_reg && level_o;
            if (s2_reg == s3_reg) begin
                level_o <= s3_reg;
            end
        end
    end

endmodule

// ==== core/sbg_prescaler.sv ====
// Power-of-two prescaler giving one enable pulse per 2^n core clocks
`timescale 1ns/1ps
module sbg_prescaler (
    input  wire logic       core_clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic       restart_i,
    input  wire logic [2:0] code_i,
    output logic            tick_o
);

    logic [sbg_pkg::SBG_PRE_W-1:0] cnt_reg;
    logic [sbg_pkg::SBG_PRE_W-1:0] term;

    // Bit i takes part only when i <= code, so the span is 2^(code+1)
    genvar gi;
    generate
        for (gi = 0; gi < sbg_pkg::SBG_PRE_W; gi = gi + 1) begin : g_term
            assign term[gi] = cnt_reg[gi] | (3'(gi) > code_i);
        end
    endgenerate

    // Free-running counter; restart keeps the first period whole
    always_ff @(posedge core_clk_i) begin
        if (rst_i || restart_i || !run_i) begin
            cnt_reg <= '0;
            tick_o  <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            tick_o  <= &term;
        end
    end

endmodule

// ==== core/sbg_baud_gen.sv ====
// Serial baud and serial clock generator with APB register access
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
module sbg_baud_gen (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    // APB slave
    input  wire logic [31:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Clock pins
    input  wire logic        ext_baud_clock_i,
    input  wire logic        sync_serial_clock_i,
    output logic             sync_serial_clock_o,
    output logic             sync_serial_clock_oe_o,
    // Timing to the shifters
    output logic             baud_x16_tick_o,
    output logic             baud_tick_o,
    output logic             sclk_rise_o,
    output logic             sclk_fall_o,
    // Mode to the shifters and pin muxes
    output logic             mode_stop_o,
    output logic             mode_uart_o,
    output logic             mode_three_wire_o,
    output logic             uart_tx_enable_o,
    output logic             uart_rx_enable_o,
    output logic             pins_serial_o
);

    // Registers
    logic [7:0] async_mode_control_reg;
    logic [7:0] serial_mode_control_reg;
    logic [7:0] baud_source_select_reg;

    // APB decode
    logic       setup_phase;
    logic       access_wr;
    logic       hit_async;
    logic       hit_mode;
    logic       hit_baud;
    logic       hit_status;
    logic       hit_any;
    logic [7:0] wbyte;

    // Mode
    sbg_pkg::sbg_mode_t mode_reg;
    sbg_pkg::sbg_mode_t mode_next;

    // Clock sourcing
    logic [3:0] source_code;
    logic       src_internal;
    logic       src_external;
    logic       three_wire_int_clk;
    logic       clk_phase;
    logic       pre_run;
    logic       pre_tick;
    logic       baud_write;
    logic       ext_level;
    logic       ext_rise;
    logic       sck_in_level;
    logic       sck_in_rise;
    logic       sck_in_fall;
    logic       x16_src;
    logic [3:0] bit_cnt_reg;
    logic       sck_reg;

    // Address decode; the byte address is four times the index
    assign hit_async  = (paddr_i == sbg_pkg::SBG_ADDR_ASYNC);
    assign hit_mode   = (paddr_i == sbg_pkg::SBG_ADDR_MODE);
    assign hit_baud   = (paddr_i == sbg_pkg::SBG_ADDR_BAUD);
    assign hit_status = (paddr_i == sbg_pkg::SBG_ADDR_STATUS);
    assign hit_any    = hit_async | hit_mode | hit_baud | hit_status;

    assign setup_phase = psel_i && !penable_i;
    assign access_wr   = psel_i && penable_i && pwrite_i && pstrb_i[0];
    assign wbyte       = pwdata_i[7:0];

    // Zero wait states: ready in every access cycle
    assign pready_o = psel_i && penable_i;

    // Read data and error captured in setup, stable through access
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else if (setup_phase) begin
            pslverr_o <= !hit_any;
            prdata_o  <= 32'h0000_0000;
            if (!pwrite_i) begin
                if (hit_async) begin
                    prdata_o[7:0] <= async_mode_control_reg;
                end else if (hit_mode) begin
                    prdata_o[7:0] <= serial_mode_control_reg;
                end else if (hit_baud) begin
                    prdata_o[7:0] <= baud_source_select_reg;
                end else if (hit_status) begin
                    prdata_o[7:0] <= {3'h0, sck_in_level, ext_level, mode_reg};
                end
            end
        end
    end

    // Asynchronous mode register; bits 1 and 0 stay zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            async_mode_control_reg <= sbg_pkg::SBG_RST_ASYNC;
        end else if (access_wr && hit_async) begin
            async_mode_control_reg <= wbyte & sbg_pkg::SBG_MASK_ASYNC;
        end
    end

    // Serial mode register; bits 5 and 4 are held at zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            serial_mode_control_reg <= sbg_pkg::SBG_RST_MODE;
        end else if (access_wr && hit_mode) begin
            serial_mode_control_reg <= wbyte & sbg_pkg::SBG_MASK_MODE;
        end
    end

    // Baud source register; low nibble reads zero
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            baud_source_select_reg <= sbg_pkg::SBG_RST_BAUD;
        end else if (access_wr && hit_baud) begin
            baud_source_select_reg <= wbyte & sbg_pkg::SBG_MASK_BAUD;
        end
    end

    // Write to the source restarts the dividers; mid-frame it breaks timing
    assign baud_write = access_wr && hit_baud;

    // Mode from both registers; 3-wire wins a prohibited overlap
    always_comb begin
        mode_next = sbg_pkg::SBG_ST_STOP;
        if (serial_mode_control_reg[sbg_pkg::SBG_BIT_3W_EN]) begin
            mode_next = sbg_pkg::SBG_ST_3W;
        end else if (async_mode_control_reg[sbg_pkg::SBG_BIT_TX_EN]
                     || async_mode_control_reg[sbg_pkg::SBG_BIT_RX_EN]) begin
            mode_next = sbg_pkg::SBG_ST_UART;
        end
    end

    // Registered mode state
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_reg <= sbg_pkg::SBG_ST_STOP;
        end else begin
            case (mode_next)
                sbg_pkg::SBG_ST_STOP: mode_reg <= sbg_pkg::SBG_ST_STOP;
                sbg_pkg::SBG_ST_UART: mode_reg <= sbg_pkg::SBG_ST_UART;
                sbg_pkg::SBG_ST_3W:   mode_reg <= sbg_pkg::SBG_ST_3W;
                default:              mode_reg <= sbg_pkg::SBG_ST_STOP;
            endcase
        end
    end

    // Mode outputs; in stop the shared pins go back to port use
    assign mode_stop_o       = (mode_reg == sbg_pkg::SBG_ST_STOP);
    assign mode_uart_o       = (mode_reg == sbg_pkg::SBG_ST_UART);
    assign mode_three_wire_o = (mode_reg == sbg_pkg::SBG_ST_3W);
    assign pins_serial_o     = !mode_stop_o;
    assign uart_tx_enable_o  = mode_uart_o
                               && async_mode_control_reg[sbg_pkg::SBG_BIT_TX_EN];
    assign uart_rx_enable_o  = mode_uart_o
                               && async_mode_control_reg[sbg_pkg::SBG_BIT_RX_EN];

    // Source code decode; prohibited codes give no baud or internal serial clock
    assign source_code  = baud_source_select_reg[sbg_pkg::SBG_SRC_LSB +: 4];
    assign src_internal = (source_code <= sbg_pkg::SBG_CODE_MAX_INT);
    // External pin is honoured in UART mode only
    assign src_external = (source_code == sbg_pkg::SBG_CODE_EXT) && mode_uart_o;

    assign three_wire_int_clk = mode_three_wire_o
                                && serial_mode_control_reg[sbg_pkg::SBG_BIT_CLK_INT];
    assign clk_phase = serial_mode_control_reg[sbg_pkg::SBG_BIT_CLK_PHASE];

    // Prescaler idles in stop mode and on external clocks to save power
    assign pre_run = src_internal && (mode_uart_o || three_wire_int_clk);

    sbg_prescaler u_pre (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .run_i      (pre_run),
        .restart_i  (baud_write),
        .code_i     (source_code[2:0]),
        .tick_o     (pre_tick)
    );

    // External baud clock pin, filtered into core clock edges
    sbg_pin_sync u_ext_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (ext_baud_clock_i),
        .level_o    (ext_level),
        .rise_o     (ext_rise),
        .fall_o     ()
    );

    // External 3-wire serial clock pin
    sbg_pin_sync u_sck_sync (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .pin_i      (sync_serial_clock_i),
        .level_o    (sck_in_level),
        .rise_o     (sck_in_rise),
        .fall_o     (sck_in_fall)
    );

    // Sixteen-times clock for the UART sampler
    always_comb begin
        x16_src = 1'b0;
        if (mode_uart_o) begin
            if (src_external) begin
                x16_src = ext_rise;
            end else if (src_internal) begin
                x16_src = pre_tick;
            end
        end
    end

    assign baud_x16_tick_o = x16_src;

    // Divide by 16 for the bit rate
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !mode_uart_o || baud_write) begin
            bit_cnt_reg <= 4'h0;
            baud_tick_o <= 1'b0;
        end else begin
            baud_tick_o <= x16_src && (bit_cnt_reg == sbg_pkg::SBG_UART_LAST);
            if (x16_src) begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    // Internal serial clock toggles per prescaler tick, halving it again
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sck_reg <= 1'b1;
        end else if (!three_wire_int_clk || !src_internal) begin
            sck_reg <= !clk_phase; // idle level is the inverse of the phase bit
        end else if (pre_tick) begin
            sck_reg <= !sck_reg;
        end
    end

    // Shift edges: own clock when internal, pin edges when external
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sclk_rise_o <= 1'b0;
            sclk_fall_o <= 1'b0;
        end else if (three_wire_int_clk) begin
            sclk_rise_o <= src_internal && pre_tick && !sck_reg;
            sclk_fall_o <= src_internal && pre_tick && sck_reg;
        end else begin
            // Source setting plays no part here
            sclk_rise_o <= mode_three_wire_o && sck_in_rise;
            sclk_fall_o <= mode_three_wire_o && sck_in_fall;
        end
    end

    // Drive the clock pin whenever 3-wire mode selects the internal clock
    assign sync_serial_clock_o    = sck_reg;
    assign sync_serial_clock_oe_o = three_wire_int_clk;

endmodule

// ==== testbench/sbg_baud_gen_monitor.sv ====
// Port-level checker for the serial baud generator
`timescale 1ns/1ps
module sbg_baud_gen_monitor (
    input  wire logic        core_clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] paddr_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    input  wire logic        pready_o,
    input  wire logic        baud_x16_tick_o,
    input  wire logic        baud_tick_o,
    input  wire logic        sclk_rise_o,
    input  wire logic        sclk_fall_o,
    input  wire logic        sync_serial_clock_oe_o,
    input  wire logic        mode_stop_o,
    input  wire logic        mode_uart_o,
    input  wire logic        mode_three_wire_o,
    input  wire logic        uart_tx_enable_o,
    input  wire logic        pins_serial_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    logic       wr;
    logic [3:0] code_reg;
    logic [9:0] per;
    logic [9:0] xgap_reg;
    logic [9:0] sgap_reg;
    logic [4:0] xcnt_reg;
    logic       xok_reg;
    logic       sok_reg;
    logic       bok_reg;

    assign wr  = psel_i & penable_i & pwrite_i & pstrb_i[0];
    assign per = 10'h002 << code_reg;

    // Shadow code and spacing counters; any write voids them, as restarts shift phase
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            code_reg <= 4'h0;
            xok_reg  <= 1'h0;
            sok_reg  <= 1'h0;
            bok_reg  <= 1'h0;
        end else begin
            if (wr && paddr_i == sbg_pkg::SBG_ADDR_BAUD) begin
                code_reg <= pwdata_i[7:4];
            end
            xok_reg <= !wr && (baud_x16_tick_o || xok_reg);
            sok_reg <= !wr && (sclk_rise_o || sclk_fall_o || sok_reg);
            bok_reg <= !wr && (baud_tick_o || bok_reg);
        end
        xgap_reg <= baud_x16_tick_o ? 10'h001 : xgap_reg + 10'h001;
        sgap_reg <= (sclk_rise_o || sclk_fall_o) ? 10'h001 : sgap_reg + 10'h001;
        xcnt_reg <= (baud_tick_o ? 5'h00 : xcnt_reg) + {4'h0, baud_x16_tick_o};
    end

    sequence s_access;
        psel_i && penable_i;
    endsequence
    sequence s_stopped;
        mode_stop_o ##1 mode_stop_o;
    endsequence

    a_pready_zero_wait: assert property (s_access |-> pready_o)
        else $error("pready missing in access cycle");
    a_mode_onehot: assert property ($onehot({mode_stop_o, mode_uart_o, mode_three_wire_o}))
        else $error("mode outputs not one-hot");
    a_stop_quiet: assert property (s_stopped |-> !pins_serial_o && !baud_x16_tick_o
        && !sclk_rise_o && !sclk_fall_o) else $error("activity in stop mode");
    a_tx_needs_uart: assert property (uart_tx_enable_o |-> mode_uart_o && !mode_stop_o)
        else $error("transmit enable outside uart mode");
    a_oe_three_wire: assert property (sync_serial_clock_oe_o |-> mode_three_wire_o)
        else $error("clock driven outside 3-wire mode");
    a_reset_stop: assert property ($fell(rst_i) |-> mode_stop_o && !sync_serial_clock_oe_o)
        else $error("not stopped after reset");
    a_x16_period: assert property (baud_x16_tick_o && xok_reg && code_reg < 4'h8
        |-> xgap_reg == per) else $error("x16 tick spacing wrong");
    a_bit_div16: assert property (baud_tick_o && bok_reg |-> xcnt_reg == 5'h10)
        else $error("bit tick not every 16 x16 ticks");
    a_sclk_period: assert property ((sclk_rise_o || sclk_fall_o) && sok_reg
        && sync_serial_clock_oe_o |-> sgap_reg == per) else $error("serial clock spacing wrong");
    a_ext_uart_only: assert property ((code_reg == 4'h8 && !mode_uart_o)[*4]
        |-> !baud_x16_tick_o) else $error("external source ticking outside uart");
endmodule

bind sbg_baud_gen sbg_baud_gen_monitor u_mon (.*);

// ==== testbench/sbg_far_end.sv ====
// Remote serial device driving the external baud and serial clock pins
`timescale 1ns/1ps
module sbg_far_end #(
    parameter int HALF_NS = 400
) (
    input  wire logic baud_run_i,
    input  wire logic sck_run_i,
    output logic      ext_baud_clock_o,
    output logic      sck_o
);
    // Clocks stand high between frames; not a free-running source
    // One process drives both pins, so each has a single driver
    initial begin
        ext_baud_clock_o = 1'h1;
        sck_o = 1'h1;
        forever begin
            #(HALF_NS);
            ext_baud_clock_o = baud_run_i ? ~ext_baud_clock_o : 1'h1;
            sck_o = sck_run_i ? ~sck_o : 1'h1;
        end
    end
endmodule

// ==== testbench/sbg_baud_gen_bench.sv ====
// Self-checking bench for the serial baud generator
`timescale 1ns/1ps
module sbg_baud_gen_bench;
    logic        clk, rst, psel, penable, pwrite, brun, srun, err, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        ext_clk, sck_in, sck_out, sck_oe, x16, btick, srise, sfall;
    logic        stop, uart, tw, txen, rxen, pins;
    logic [3:0]  pstrb;
    int          bad_count, num_checks, n;

    sbg_baud_gen DUT (.core_clk_i(clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .ext_baud_clock_i(ext_clk), .sync_serial_clock_i(sck_in),
        .sync_serial_clock_o(sck_out), .sync_serial_clock_oe_o(sck_oe),
        .baud_x16_tick_o(x16), .baud_tick_o(btick), .sclk_rise_o(srise),
        .sclk_fall_o(sfall), .mode_stop_o(stop), .mode_uart_o(uart),
        .mode_three_wire_o(tw), .uart_tx_enable_o(txen), .uart_rx_enable_o(rxen),
        .pins_serial_o(pins));
    sbg_far_end u_far (.baud_run_i(brun), .sck_run_i(srun), .ext_baud_clock_o(ext_clk),
        .sck_o(sck_in));

    always #20 clk = ~clk;

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One APB transfer; holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'h1 && k < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        if (k >= 50) begin
            bad_count++;
            wrap_up();
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: pick = x16;
            1: pick = btick;
            default: pick = srise;
        endcase
    endfunction
    // Cycles between two successive pulses of one strobe
    task automatic gap(input int s);
        int k;
        k = 0;
        n = 0;
        do begin @(posedge clk); #1; k++; end while (pick(s) !== 1'h1 && k < 9000);
        do begin @(posedge clk); #1; n++; end while (pick(s) !== 1'h1 && n < 9000);
        if (n >= 9000) begin
            bad_count++;
            wrap_up();
        end
    endtask

    task automatic t_reset;
        apb(1'h0, sbg_pkg::SBG_ADDR_MODE, 32'h0);
        chk("mode reg", 32'h0, rd);
        apb(1'h0, sbg_pkg::SBG_ADDR_BAUD, 32'h0);
        chk("baud reg", 32'h0, rd);
        apb(1'h0, sbg_pkg::SBG_ADDR_STATUS, 32'h0);
        chk("status mode", 32'h1, {29'h0, rd[2:0]});
        chk("pins serial", 32'h0, 32'(pins));
        $display("reset test done");
    endtask
    task automatic t_uart;
        apb(1'h1, sbg_pkg::SBG_ADDR_ASYNC, 32'h80);
        // Codes 0 and 1 overrun the UART rate at this core clock
        for (int c = 2; c < 8; c++) begin
            apb(1'h1, sbg_pkg::SBG_ADDR_BAUD, 32'(c << 4));
            gap(0);
            chk("x16 gap", 32'h2 << c, 32'(n));
        end
        apb(1'h1, sbg_pkg::SBG_ADDR_BAUD, 32'h20);
        gap(1);
        chk("bit gap", 32'h80, 32'(n));
        chk("uart mode", 32'h1, 32'(uart));
        apb(1'h1, sbg_pkg::SBG_ADDR_ASYNC, 32'h40);
        // Mode state follows one cycle after the register
        repeat (2) @(posedge clk);
        #1;
        chk("rx only not stop", 32'h0, 32'(stop));
        chk("tx enable", 32'h0, 32'(txen));
        chk("rx enable", 32'h1, 32'(rxen));
        $display("uart test done");
    endtask
    task automatic t_ext;
        apb(1'h1, sbg_pkg::SBG_ADDR_BAUD, 32'h80);
        brun <= 1'h1;
        gap(0);
        chk("ext x16 gap", 32'h14, 32'(n));
        gap(1);
        chk("ext bit gap", 32'h140, 32'(n));
        $display("external test done");
    endtask
    task automatic t_3wire;
        int k;
        apb(1'h1, sbg_pkg::SBG_ADDR_ASYNC, 32'h0);
        // External clock keeps running, but with UART off it is ignored
        k = 0;
        repeat (40) begin
            @(posedge clk);
            #1;
            if (x16 !== 1'h0) k++;
        end
        chk("ext outside uart", 32'h0, 32'(k));
        apb(1'h1, sbg_pkg::SBG_ADDR_BAUD, 32'h20);
        brun <= 1'h0;
        apb(1'h1, sbg_pkg::SBG_ADDR_MODE, 32'h82);
        gap(2);
        chk("sclk period", 32'h10, 32'(n));
        chk("sclk high at rise", 32'h1, 32'(sck_out));
        chk("sclk oe", 32'h1, 32'(sck_oe));
        chk("3-wire mode", 32'h1, 32'(tw));
        apb(1'h1, sbg_pkg::SBG_ADDR_MODE, 32'h80);
        srun <= 1'h1;
        gap(2);
        chk("ext sclk period", 32'h14, 32'(n));
        chk("ext sclk oe", 32'h0, 32'(sck_oe));
        chk("sclk idle", 32'h1, 32'(sck_out));
        srun <= 1'h0;
        $display("3-wire test done");
    endtask
    task automatic t_stop;
        int k;
        apb(1'h1, sbg_pkg::SBG_ADDR_MODE, 32'h0);
        repeat (4) @(posedge clk);
        k = 0;
        repeat (300) begin
            @(posedge clk);
            #1;
            if ((x16 | btick | srise | sfall) !== 1'h0) k++;
        end
        chk("stop ticks", 32'h0, 32'(k));
        chk("stop mode", 32'h1, 32'(stop));
        apb(1'h0, 32'h0, 32'h0);
        chk("unmapped err", 32'h1, 32'(err));
        // Low lane strobe off: the write must be dropped
        pstrb <= 4'h0;
        apb(1'h1, sbg_pkg::SBG_ADDR_MODE, 32'h82);
        pstrb <= 4'hf;
        apb(1'h0, sbg_pkg::SBG_ADDR_MODE, 32'h0);
        chk("strobe off write", 32'h0, rd);
        $display("stop test done");
    endtask

    initial begin
        clk = 1'h0;
        rst = 1'h1;
        {psel, penable, pwrite, brun, srun} = 5'h0;
        paddr = 32'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        bad_count = 0;
        num_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_uart();
        t_ext();
        t_3wire();
        t_stop();
        wrap_up();
    end
endmodule
